// ### hdl/rvd_pkg.sv
/*
  Decoder constants and types: field positions,
  codes and enumerations.
  Assumes users import the whole package.
*/
// Operation
// RL1 - Low bits 11 select 32-bit opcode map
// RL2 - Row 00 majors: load through immediate-32
// RL3 - Row 01 majors: store through register-32
// RL4 - Row 10 majors: fused groups, fp, vector, custom
// RL5 - Row 11 majors: branch, jumps, system, custom
// RL6 - Bits 4:2 all ones escape to longer instruction
// RL7 - Register layout field positions
// RL8 - Immediate layout twelve bits from 31:20
// RL9 - Store immediate split 31:25 and 11:7
// RL10 - Branch immediate bit scatter
// RL11 - Upper-immediate and add-upper-to-pc decode
// RL12 - Jump-and-link immediate scatter
// RL13 - Jump-and-link-register with funct3 000
// RL14 - Conditional branches by funct3
// RL15 - Loads by funct3
// RL16 - Stores by funct3
// RL17 - Immediate arithmetic by funct3
// RL18 - Immediate shifts by funct7 and funct3
// RL19 - Register arithmetic by funct7 and funct3
// RL20 - Fence fields and total-store-order fence
// RL21 - Pause hint fence encoding
// RL22 - Environment call and breakpoint
// RL23 - Unmatched words flagged illegal
// RL24 - Purely combinational, no state
`default_nettype none

package rvd_pkg;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned RD_LSB = 7;
  localparam int unsigned F3_LSB = 12;
  localparam int unsigned RS1_LSB = 15;
  localparam int unsigned RS2_LSB = 20;
  localparam int unsigned F7_LSB = 25;
  localparam int unsigned SUCC_LSB = 20;
  localparam int unsigned PRED_LSB = 24;
  localparam int unsigned FM_LSB = 28;

  // ****************************************************************
  // Codes
  // ****************************************************************
  localparam logic [1:0] LOW_WORD32 = 2'h3;
  localparam logic [2:0] ESCAPE_COL = 3'h7;
  localparam logic [6:0] OPC_LUI = 7'h37;
  localparam logic [6:0] OPC_AUIPC = 7'h17;
  localparam logic [6:0] OPC_JAL = 7'h6F;
  localparam logic [6:0] OPC_JALR = 7'h67;
  localparam logic [6:0] OPC_BRANCH = 7'h63;
  localparam logic [6:0] OPC_LOAD = 7'h03;
  localparam logic [6:0] OPC_STORE = 7'h23;
  localparam logic [6:0] OPC_OPIMM = 7'h13;
  localparam logic [6:0] OPC_OP = 7'h33;
  localparam logic [6:0] OPC_MISCMEM = 7'h0F;
  localparam logic [6:0] OPC_SYSTEM = 7'h73;
  localparam logic [6:0] F7_BASE = 7'h00;
  localparam logic [6:0] F7_ALT = 7'h20;
  localparam logic [3:0] FM_PLAIN = 4'h0;
  localparam logic [3:0] FM_TSO = 4'h8;
  localparam logic [3:0] SET_RW = 4'h3;
  localparam logic [3:0] SET_W = 4'h1;
  localparam logic [3:0] SET_NONE = 4'h0;
  localparam logic [4:0] REG_ZERO = 5'h00;
  localparam logic [11:0] IMM_ECALL = 12'h000;
  localparam logic [11:0] IMM_EBREAK = 12'h001;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [4:0] {
    MAJ_LOAD = 5'h00, MAJ_LOAD_FP = 5'h01, MAJ_CUSTOM0 = 5'h02,
    MAJ_MISC_MEM = 5'h03, MAJ_OP_IMM = 5'h04, MAJ_AUIPC = 5'h05,
    MAJ_OP_IMM32 = 5'h06, MAJ_ESC48A = 5'h07, MAJ_STORE = 5'h08,
    MAJ_STORE_FP = 5'h09, MAJ_CUSTOM1 = 5'h0A, MAJ_AMO = 5'h0B,
    MAJ_OP = 5'h0C, MAJ_LUI = 5'h0D, MAJ_OP32 = 5'h0E,
    MAJ_ESC64 = 5'h0F, MAJ_MADD = 5'h10, MAJ_MSUB = 5'h11,
    MAJ_NMSUB = 5'h12, MAJ_NMADD = 5'h13, MAJ_OP_FP = 5'h14,
    MAJ_OP_V = 5'h15, MAJ_CUSTOM2 = 5'h16, MAJ_ESC48B = 5'h17,
    MAJ_BRANCH = 5'h18, MAJ_JALR = 5'h19, MAJ_RESERVED = 5'h1A,
    MAJ_JAL = 5'h1B, MAJ_SYSTEM = 5'h1C, MAJ_OP_VE = 5'h1D,
    MAJ_CUSTOM3 = 5'h1E, MAJ_ESC80 = 5'h1F
  } rvd_major_type;

  typedef enum logic [2:0] {
    LEN_16 = 3'h0, LEN_32 = 3'h1, LEN_48 = 3'h2, LEN_64 = 3'h3,
    LEN_80P = 3'h4
  } rvd_len_type;

  typedef enum logic [2:0] {
    FMT_NONE = 3'h0, FMT_R = 3'h1, FMT_I = 3'h2, FMT_S = 3'h3,
    FMT_B = 3'h4, FMT_U = 3'h5, FMT_J = 3'h6
  } rvd_fmt_type;

  typedef enum logic [5:0] {
    OP_ILLEGAL = 6'h00, OP_LUI = 6'h01, OP_AUIPC = 6'h02,
    OP_JAL = 6'h03, OP_JALR = 6'h04, OP_BEQ = 6'h05, OP_BNE = 6'h06,
    OP_BLT = 6'h07, OP_BGE = 6'h08, OP_BLTU = 6'h09, OP_BGEU = 6'h0A,
    OP_LB = 6'h0B, OP_LH = 6'h0C, OP_LW = 6'h0D, OP_LBU = 6'h0E,
    OP_LHU = 6'h0F, OP_SB = 6'h10, OP_SH = 6'h11, OP_SW = 6'h12,
    OP_ADDI = 6'h13, OP_SLTI = 6'h14, OP_SLTIU = 6'h15,
    OP_XORI = 6'h16, OP_ORI = 6'h17, OP_ANDI = 6'h18, OP_SLLI = 6'h19,
    OP_SRLI = 6'h1A, OP_SRAI = 6'h1B, OP_ADD = 6'h1C, OP_SUB = 6'h1D,
    OP_SLL = 6'h1E, OP_SLT = 6'h1F, OP_SLTU = 6'h20, OP_XOR = 6'h21,
    OP_SRL = 6'h22, OP_SRA = 6'h23, OP_OR = 6'h24, OP_AND = 6'h25,
    OP_FENCE = 6'h26, OP_FENCE_TSO = 6'h27, OP_PAUSE = 6'h28,
    OP_ECALL = 6'h29, OP_EBREAK = 6'h2A
  } rvd_op_type;

endpackage : rvd_pkg

`default_nettype wire

// ### hdl/rvd_opmap.sv
/*
  Major opcode and length classifier.
  Assumes the word is stable for as long as the result is used.
*/
`timescale 1ns/1ps
`default_nettype none

module rvd_opmap
  import rvd_pkg::*;
(
  // Instruction word
  input wire logic [31:0] word,
  // Classification
  output rvd_major_type major,
  output rvd_len_type len,
  output logic word32
);

  // Enum codes equal bits 6:2
  assign major = rvd_major_type'(word[6:2]); // RL2 RL3 RL4 RL5
  assign word32 = (word[1:0] == LOW_WORD32) &&
                  (word[4:2] != ESCAPE_COL); // RL1 RL6

  always_comb
  begin
    len = LEN_16;
    if (word[1:0] == LOW_WORD32) // RL1
    begin
      if (word[4:2] != ESCAPE_COL)
      begin
        len = LEN_32;
      end
      else
      begin
        unique case (word[6:5]) // RL6
          2'h0, 2'h2: len = LEN_48;
          2'h1: len = LEN_64;
          2'h3: len = LEN_80P;
        endcase
      end
    end
  end

endmodule : rvd_opmap

`default_nettype wire

// ### hdl/rvd_fields.sv
/*
  Field splitter: slices and sign-extended immediates.
  Assumes a word from the 32-bit opcode map.
*/
`timescale 1ns/1ps
`default_nettype none

module rvd_fields
  import rvd_pkg::*;
(
  // Instruction word
  input wire logic [31:0] word,
  // Register layout fields
  output logic [6:0] opcode,
  output logic [4:0] rd,
  output logic [2:0] funct3,
  output logic [4:0] rs1,
  output logic [4:0] rs2,
  output logic [6:0] funct7,
  // Fence fields
  output logic [3:0] fence_fm,
  output logic [3:0] fence_pred,
  output logic [3:0] fence_succ,
  // Immediates
  output logic [11:0] imm12,
  output logic [31:0] imm_i,
  output logic [31:0] imm_s,
  output logic [31:0] imm_b,
  output logic [31:0] imm_u,
  output logic [31:0] imm_j
);

  assign opcode = word[6:0]; // RL7
  assign rd = word[RD_LSB +: 5]; // RL7
  assign funct3 = word[F3_LSB +: 3]; // RL7
  assign rs1 = word[RS1_LSB +: 5]; // RL7
  assign rs2 = word[RS2_LSB +: 5]; // RL7
  assign funct7 = word[F7_LSB +: 7]; // RL7
  assign fence_fm = word[FM_LSB +: 4]; // RL20
  assign fence_pred = word[PRED_LSB +: 4]; // RL20
  assign fence_succ = word[SUCC_LSB +: 4]; // RL20
  assign imm12 = word[31:20]; // RL8
  assign imm_i = {{20{word[31]}}, word[31:20]}; // RL8
  assign imm_s = {{20{word[31]}}, word[31:25], word[11:7]}; // RL9
  assign imm_b = {{19{word[31]}}, word[31], word[7],
                  word[30:25], word[11:8], 1'b0}; // RL10
  assign imm_u = {word[31:12], 12'h000}; // RL11
  assign imm_j = {{11{word[31]}}, word[31], word[19:12],
                  word[20], word[30:21], 1'b0}; // RL12

endmodule : rvd_fields

`default_nettype wire

// ### hdl/rvd_decoder.sv
/*
  Decoder top: map, length, fields, operation
  and an illegal flag for unsupported words.
  Assumes the fetch stage holds the word
  while the execute datapath samples it;
  no clock and no state.
*/
`timescale 1ns/1ps
`default_nettype none

module rvd_decoder
  import rvd_pkg::*;
(
  // Word from the fetch stage
  input wire logic [31:0] instr_word,
  // Map and length
  output rvd_major_type major,
  output rvd_len_type insn_len,
  output logic is_word32,
  // Register layout fields
  output logic [6:0] opcode,
  output logic [4:0] rd,
  output logic [2:0] funct3,
  output logic [4:0] rs1,
  output logic [4:0] rs2,
  output logic [6:0] funct7,
  output logic [4:0] shamt,
  // Fence fields
  output logic [3:0] fence_fm,
  output logic [3:0] fence_pred,
  output logic [3:0] fence_succ,
  // Operation
  output rvd_op_type op_id,
  output rvd_fmt_type fmt,
  output logic [31:0] imm,
  output logic illegal,
  // Operand use
  output logic uses_rs1,
  output logic uses_rs2,
  output logic writes_rd,
  // Classes
  output logic is_branch,
  output logic is_jump,
  output logic is_load,
  output logic is_store,
  output logic [1:0] mem_size,
  output logic mem_unsigned,
  output logic alu_alt,
  // Ordering and system events
  output logic is_fence,
  output logic fence_tso,
  output logic pause_hint,
  output logic env_call,
  output logic env_break
);

  // ****************************************************************
  // Decode result
  // ****************************************************************
  typedef struct packed {
    rvd_op_type op;
    rvd_fmt_type fmt;
    logic illegal;
    logic uses_rs1;
    logic uses_rs2;
    logic writes_rd;
    logic is_branch;
    logic is_jump;
    logic is_load;
    logic is_store;
    logic [1:0] mem_size;
    logic mem_unsigned;
    logic alu_alt;
    logic is_fence;
    logic fence_tso;
    logic pause_hint;
    logic env_call;
    logic env_break;
  } rvd_dec_type;

  rvd_dec_type dec_next;
  logic [11:0] imm12;
  logic [31:0] imm_i;
  logic [31:0] imm_s;
  logic [31:0] imm_b;
  logic [31:0] imm_u;
  logic [31:0] imm_j;
  logic fence_zero_regs;

  // ****************************************************************
  // Map, length and fields
  // ****************************************************************
  rvd_opmap u_opmap (
    .word(instr_word),
    .major(major),
    .len(insn_len),
    .word32(is_word32)
  );

  rvd_fields u_fields (
    .word(instr_word),
    .opcode(opcode),
    .rd(rd),
    .funct3(funct3),
    .rs1(rs1),
    .rs2(rs2),
    .funct7(funct7),
    .fence_fm(fence_fm),
    .fence_pred(fence_pred),
    .fence_succ(fence_succ),
    .imm12(imm12),
    .imm_i(imm_i),
    .imm_s(imm_s),
    .imm_b(imm_b),
    .imm_u(imm_u),
    .imm_j(imm_j)
  );

  // Shift amount sits where rs2 would be
  assign shamt = rs2; // RL18
  assign fence_zero_regs = (rs1 == REG_ZERO) && (rd == REG_ZERO);

  // ****************************************************************
  // Operation decode
  // ****************************************************************
  // A word is illegal until a supported encoding claims it
  always_comb
  begin
    dec_next = '0;
    dec_next.op = OP_ILLEGAL;
    dec_next.fmt = FMT_NONE;
    dec_next.illegal = 1'b1; // RL23
    if (is_word32) // RL1
    begin
      unique case (opcode)
        OPC_LUI, OPC_AUIPC:
        begin
          dec_next.op = (opcode == OPC_LUI) ? OP_LUI : OP_AUIPC; // RL11
          dec_next.fmt = FMT_U; // RL11
          dec_next.writes_rd = 1'b1;
          dec_next.illegal = 1'b0;
        end
        OPC_JAL:
        begin
          dec_next.op = OP_JAL; // RL12
          dec_next.fmt = FMT_J; // RL12
          dec_next.writes_rd = 1'b1;
          dec_next.is_jump = 1'b1;
          dec_next.illegal = 1'b0;
        end
        OPC_JALR:
        begin
          if (funct3 == 3'h0) // RL13
          begin
            dec_next.op = OP_JALR;
            dec_next.fmt = FMT_I; // RL13
            dec_next.uses_rs1 = 1'b1;
            dec_next.writes_rd = 1'b1;
            dec_next.is_jump = 1'b1;
            dec_next.illegal = 1'b0;
          end
        end
        OPC_BRANCH:
        begin
          dec_next.fmt = FMT_B;
          dec_next.uses_rs1 = 1'b1;
          dec_next.uses_rs2 = 1'b1;
          dec_next.is_branch = 1'b1;
          dec_next.illegal = 1'b0;
          unique case (funct3) // RL14
            3'h0: dec_next.op = OP_BEQ;
            3'h1: dec_next.op = OP_BNE;
            3'h4: dec_next.op = OP_BLT;
            3'h5: dec_next.op = OP_BGE;
            3'h6: dec_next.op = OP_BLTU;
            3'h7: dec_next.op = OP_BGEU;
            default:
            begin
              dec_next = '0;
              dec_next.op = OP_ILLEGAL;
              dec_next.illegal = 1'b1; // RL23
            end
          endcase
        end
        OPC_LOAD:
        begin
          dec_next.fmt = FMT_I;
          dec_next.uses_rs1 = 1'b1;
          dec_next.writes_rd = 1'b1;
          dec_next.is_load = 1'b1;
          dec_next.mem_size = funct3[1:0];
          dec_next.mem_unsigned = funct3[2];
          dec_next.illegal = 1'b0;
          unique case (funct3) // RL15
            3'h0: dec_next.op = OP_LB;
            3'h1: dec_next.op = OP_LH;
            3'h2: dec_next.op = OP_LW;
            3'h4: dec_next.op = OP_LBU;
            3'h5: dec_next.op = OP_LHU;
            default:
            begin
              dec_next = '0;
              dec_next.op = OP_ILLEGAL;
              dec_next.illegal = 1'b1; // RL23
            end
          endcase
        end
        OPC_STORE:
        begin
          dec_next.fmt = FMT_S; // RL9
          dec_next.uses_rs1 = 1'b1;
          dec_next.uses_rs2 = 1'b1;
          dec_next.is_store = 1'b1;
          dec_next.mem_size = funct3[1:0];
          dec_next.illegal = 1'b0;
          unique case (funct3) // RL16
            3'h0: dec_next.op = OP_SB;
            3'h1: dec_next.op = OP_SH;
            3'h2: dec_next.op = OP_SW;
            default:
            begin
              dec_next = '0;
              dec_next.op = OP_ILLEGAL;
              dec_next.illegal = 1'b1; // RL23
            end
          endcase
        end
        OPC_OPIMM:
        begin
          dec_next.fmt = FMT_I; // RL8
          dec_next.uses_rs1 = 1'b1;
          dec_next.writes_rd = 1'b1;
          dec_next.illegal = 1'b0;
          unique case (funct3) // RL17
            3'h0: dec_next.op = OP_ADDI;
            3'h2: dec_next.op = OP_SLTI;
            3'h3: dec_next.op = OP_SLTIU;
            3'h4: dec_next.op = OP_XORI;
            3'h6: dec_next.op = OP_ORI;
            3'h7: dec_next.op = OP_ANDI;
            3'h1:
            begin
              dec_next.op = OP_SLLI; // RL18
              dec_next.illegal = (funct7 != F7_BASE); // RL18
            end
            3'h5:
            begin
              dec_next.op = (funct7 == F7_ALT) ? OP_SRAI : OP_SRLI; // RL18
              dec_next.alu_alt = (funct7 == F7_ALT);
              dec_next.illegal = (funct7 != F7_BASE) &&
                                 (funct7 != F7_ALT); // RL18
            end
          endcase
          if (dec_next.illegal)
          begin
            dec_next = '0;
            dec_next.op = OP_ILLEGAL;
            dec_next.illegal = 1'b1; // RL23
          end
        end
        OPC_OP:
        begin
          dec_next.fmt = FMT_R; // RL7
          dec_next.uses_rs1 = 1'b1;
          dec_next.uses_rs2 = 1'b1;
          dec_next.writes_rd = 1'b1;
          dec_next.alu_alt = (funct7 == F7_ALT);
          dec_next.illegal = 1'b0;
          if (funct7 == F7_BASE) // RL19
          begin
            unique case (funct3)
              3'h0: dec_next.op = OP_ADD;
              3'h1: dec_next.op = OP_SLL;
              3'h2: dec_next.op = OP_SLT;
              3'h3: dec_next.op = OP_SLTU;
              3'h4: dec_next.op = OP_XOR;
              3'h5: dec_next.op = OP_SRL;
              3'h6: dec_next.op = OP_OR;
              3'h7: dec_next.op = OP_AND;
            endcase
          end
          else if (funct7 == F7_ALT && funct3 == 3'h0) // RL19
          begin
            dec_next.op = OP_SUB;
          end
          else if (funct7 == F7_ALT && funct3 == 3'h5) // RL19
          begin
            dec_next.op = OP_SRA;
          end
          else
          begin
            dec_next = '0;
            dec_next.op = OP_ILLEGAL;
            dec_next.illegal = 1'b1; // RL23
          end
        end
        OPC_MISCMEM:
        begin
          if (funct3 == 3'h0) // RL20
          begin
            dec_next.op = OP_FENCE;
            dec_next.fmt = FMT_I;
            dec_next.is_fence = 1'b1;
            dec_next.illegal = 1'b0;
            if (fence_fm == FM_TSO && fence_pred == SET_RW &&
                fence_succ == SET_RW && fence_zero_regs) // RL20
            begin
              dec_next.op = OP_FENCE_TSO;
              dec_next.fence_tso = 1'b1;
            end
            if (fence_fm == FM_PLAIN && fence_pred == SET_W &&
                fence_succ == SET_NONE && fence_zero_regs) // RL21
            begin
              dec_next.op = OP_PAUSE;
              dec_next.pause_hint = 1'b1;
            end
          end
        end
        OPC_SYSTEM:
        begin
          if (funct3 == 3'h0 && fence_zero_regs) // RL22
          begin
            if (imm12 == IMM_ECALL) // RL22
            begin
              dec_next.op = OP_ECALL;
              dec_next.fmt = FMT_I;
              dec_next.env_call = 1'b1;
              dec_next.illegal = 1'b0;
            end
            else if (imm12 == IMM_EBREAK) // RL22
            begin
              dec_next.op = OP_EBREAK;
              dec_next.fmt = FMT_I;
              dec_next.env_break = 1'b1;
              dec_next.illegal = 1'b0;
            end
          end
        end
        default:
        begin
          dec_next.illegal = 1'b1; // RL23
        end
      endcase
    end
  end

  // ****************************************************************
  // Immediate select
  // ****************************************************************
  always_comb
  begin
    unique case (dec_next.fmt)
      FMT_I: imm = imm_i; // RL8
      FMT_S: imm = imm_s; // RL9
      FMT_B: imm = imm_b; // RL10
      FMT_U: imm = imm_u; // RL11
      FMT_J: imm = imm_j; // RL12
      default: imm = 32'h0000_0000;
    endcase
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // No flip-flops: every output follows the word in the same cycle
  assign op_id = dec_next.op; // RL24
  assign fmt = dec_next.fmt;
  assign illegal = dec_next.illegal; // RL23
  assign uses_rs1 = dec_next.uses_rs1;
  assign uses_rs2 = dec_next.uses_rs2;
  assign writes_rd = dec_next.writes_rd;
  assign is_branch = dec_next.is_branch;
  assign is_jump = dec_next.is_jump;
  assign is_load = dec_next.is_load;
  assign is_store = dec_next.is_store;
  assign mem_size = dec_next.mem_size;
  assign mem_unsigned = dec_next.mem_unsigned;
  assign alu_alt = dec_next.alu_alt;
  assign is_fence = dec_next.is_fence;
  assign fence_tso = dec_next.fence_tso;
  assign pause_hint = dec_next.pause_hint;
  assign env_call = dec_next.env_call;
  assign env_break = dec_next.env_break;

endmodule : rvd_decoder

`default_nettype wire

// ### tb/rvd_decoder_asserts.sv
/* Checker for the decoder outputs, sampled on the bench clock.
   Assumes the bench top holds sys_clk and arst_n. */
`timescale 1ns/1ps
`default_nettype none

module rvd_decoder_asserts
  import rvd_pkg::*;
(
  // Bench clock
  input wire logic sys_clk,
  input wire logic arst_n,
  // Decoder ports
  input wire logic [31:0] instr_word,
  input var rvd_major_type major,
  input var rvd_len_type insn_len,
  input wire logic is_word32,
  input wire logic [4:0] rd,
  input wire logic [4:0] rs1,
  input wire logic [4:0] rs2,
  input wire logic [6:0] funct7,
  input var rvd_op_type op_id,
  input var rvd_fmt_type fmt,
  input wire logic [31:0] imm,
  input wire logic illegal,
  input wire logic fence_tso,
  input wire logic env_call
);
  // ****
  // Properties
  // ****
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  logic [31:0] w;
  assign w = instr_word;
  chk_word_class: assert property (
    is_word32 == (w[1:0] == 2'h3 && w[4:2] != 3'h7))
    else $error("word class flag wrong");
  chk_escape_len: assert property (
    (w[1:0] == 2'h3 && w[4:2] == 3'h7) |-> insn_len == (w[6:5] == 2'h1 ?
    LEN_64 : w[6:5] == 2'h3 ? LEN_80P : LEN_48))
    else $error("escape length wrong");
  chk_major_code: assert property (
    is_word32 |-> major == w[6:2]) else $error("major opcode wrong");
  chk_reg_fields: assert property (
    rd == w[11:7] && rs1 == w[19:15] && rs2 == w[24:20] &&
    funct7 == w[31:25]) else $error("register fields wrong");
  chk_store_imm: assert property (
    fmt == FMT_S |-> imm == {{20{w[31]}}, w[31:25], w[11:7]})
    else $error("store immediate wrong");
  chk_branch_imm: assert property (
    fmt == FMT_B |-> imm == {{20{w[31]}}, w[7], w[30:25], w[11:8], 1'b0})
    else $error("branch immediate wrong");
  chk_jump_imm: assert property (
    fmt == FMT_J |-> imm == {{12{w[31]}}, w[19:12], w[20], w[30:21], 1'b0})
    else $error("jump immediate wrong");
  chk_illegal_quiet: assert property (
    illegal |-> op_id == OP_ILLEGAL && fmt == FMT_NONE && imm == 32'h0)
    else $error("illegal word not quiet");
  chk_tso_exact: assert property (
    fence_tso |-> w == 32'h8330000F) else $error("tso fence on wrong word");
  chk_no_state: assert property (
    $stable(instr_word) |-> $stable(op_id) && $stable(imm) &&
    $stable(illegal)) else $error("outputs move on a held word");
  cov_illegal: cover property (illegal);
  cov_ecall: cover property (env_call);
  cov_tso: cover property (fence_tso);
endmodule : rvd_decoder_asserts

bind rvd_decoder rvd_decoder_asserts chk_u (
  .sys_clk(testbench.sys_clk), .arst_n(testbench.arst_n),
  .instr_word(instr_word), .major(major), .insn_len(insn_len),
  .is_word32(is_word32), .rd(rd), .rs1(rs1), .rs2(rs2), .funct7(funct7),
  .op_id(op_id), .fmt(fmt), .imm(imm), .illegal(illegal),
  .fence_tso(fence_tso), .env_call(env_call));

`default_nettype wire

// ### tb/rvd_fetch_model.sv
/* Fetch stage model: presents one word a cycle to the decoder.
   Assumes the bench hands the next word before each rising edge. */
`timescale 1ns/1ps
`default_nettype none

module rvd_fetch_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Word asked for by the bench
  input wire logic [31:0] next_word,
  // Word shown to the decoder
  output logic [31:0] instr_word
);
  // Word held a whole cycle so the decode is read settled
  always_ff @(posedge sys_clk or negedge arst_n)
    if (!arst_n)
      instr_word <= 32'h00000000;
    else
      instr_word <= next_word;
endmodule : rvd_fetch_model

`default_nettype wire

// ### tb/testbench.sv
/* Self-checking bench for the instruction decoder.
   Assumes the fetch model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import rvd_pkg::*;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [31:0] next_word = 32'h00000000;
  logic [31:0] w;
  rvd_major_type major;
  rvd_len_type insn_len;
  rvd_op_type op_id;
  rvd_fmt_type fmt;
  logic [31:0] imm;
  logic [4:0] rd, rs1;
  logic [1:0] mem_size;
  logic is_word32, illegal, alu_alt, is_fence, fence_tso, pause_hint;
  logic env_call, env_break;
  int error_cnt = 0;
  int checks_done = 0;

  rvd_fetch_model fetch_u (.sys_clk(sys_clk), .arst_n(arst_n),
    .next_word(next_word), .instr_word(w));
  rvd_decoder dut_u (.instr_word(w), .major(major), .insn_len(insn_len),
    .is_word32(is_word32), .opcode(), .rd(rd), .funct3(), .rs1(rs1),
    .rs2(), .funct7(), .shamt(), .fence_fm(), .fence_pred(),
    .fence_succ(), .op_id(op_id), .fmt(fmt), .imm(imm),
    .illegal(illegal), .uses_rs1(), .uses_rs2(), .writes_rd(),
    .is_branch(), .is_jump(), .is_load(), .is_store(),
    .mem_size(mem_size), .mem_unsigned(), .alu_alt(alu_alt),
    .is_fence(is_fence), .fence_tso(fence_tso), .pause_hint(pause_hint),
    .env_call(env_call), .env_break(env_break));

  // ****
  // Shared tasks
  // ****
  task automatic check(input string name, input logic [31:0] seen,
    input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic apply(input logic [31:0] word);
    @(posedge sys_clk);
    next_word <= word;
    @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : apply

  task automatic try_op(input logic [31:0] word, input rvd_op_type exp);
    apply(word);
    check("op_id", op_id, exp);
    check("illegal", illegal, exp == OP_ILLEGAL);
  endtask : try_op

  function automatic logic [31:0] enc(input logic [6:0] f7,
    input logic [2:0] f3, input logic [6:0] opc);
    return {f7, 5'h0A, 5'h05, f3, 5'h03, opc};
  endfunction : enc

  // ****
  // Scenarios
  // ****
  task automatic run_map();
    rvd_len_type el;
    for (int i = 0; i < 32; i++)
    begin
      el = (i[2:0] != 3'h7) ? LEN_32 : (i[4:3] == 2'h1) ? LEN_64 :
        (i[4:3] == 2'h3) ? LEN_80P : LEN_48;
      apply({25'h0, i[4:0], 2'h3});
      check("major", major, i[4:0]);
      check("insn_len", insn_len, el);
      check("is_word32", is_word32, i[2:0] != 3'h7);
    end
    apply(32'h00000010);
    check("len16", insn_len, LEN_16);
  endtask : run_map

  task automatic run_groups();
    logic [2:0] bf [6] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6, 3'h7};
    logic [2:0] lf [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5};
    logic [2:0] af [6] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7};
    rvd_op_type ro [8] = '{OP_ADD, OP_SLL, OP_SLT, OP_SLTU, OP_XOR,
      OP_SRL, OP_OR, OP_AND};
    for (int k = 0; k < 6; k++)
    begin
      try_op(enc(7'h00, bf[k], OPC_BRANCH), rvd_op_type'(OP_BEQ + k));
      try_op(enc(7'h00, af[k], OPC_OPIMM), rvd_op_type'(OP_ADDI + k));
    end
    for (int k = 0; k < 5; k++)
    begin
      try_op(enc(7'h00, lf[k], OPC_LOAD), rvd_op_type'(OP_LB + k));
      check("mem_size", mem_size, lf[k][1:0]);
    end
    for (int k = 0; k < 3; k++)
      try_op(enc(7'h00, k[2:0], OPC_STORE), rvd_op_type'(OP_SB + k));
    for (int k = 0; k < 8; k++)
      try_op(enc(F7_BASE, k[2:0], OPC_OP), ro[k]);
    try_op(enc(F7_ALT, 3'h0, OPC_OP), OP_SUB);
    check("alu_alt", alu_alt, 1'b1);
    try_op(enc(F7_ALT, 3'h5, OPC_OP), OP_SRA);
    try_op(enc(F7_BASE, 3'h1, OPC_OPIMM), OP_SLLI);
    try_op(enc(F7_BASE, 3'h5, OPC_OPIMM), OP_SRLI);
    try_op(enc(F7_ALT, 3'h5, OPC_OPIMM), OP_SRAI);
    try_op(enc(7'h00, 3'h0, OPC_AUIPC), OP_AUIPC);
  endtask : run_groups

  task automatic run_imms();
    try_op({7'h5A, 5'h0C, 5'h11, 3'h2, 5'h17, OPC_STORE}, OP_SW);
    check("imm_s", imm, 32'hFFFFFB57);
    try_op({7'h65, 5'h0C, 5'h11, 3'h0, 5'h17, OPC_BRANCH}, OP_BEQ);
    check("imm_b", imm, 32'hFFFFFCB6);
    try_op({20'hA5C3E, 5'h01, OPC_JAL}, OP_JAL);
    check("imm_j", imm, 32'hFFF3E25C);
    try_op({20'hA5C3E, 5'h02, OPC_LUI}, OP_LUI);
    check("imm_u", imm, 32'hA5C3E000);
    check("rd_u", rd, 5'h02);
    try_op({12'h9AB, 5'h05, 3'h0, 5'h04, OPC_JALR}, OP_JALR);
    check("imm_i", imm, 32'hFFFFF9AB);
    check("rs1_i", rs1, 5'h05);
    check("fmt_i", fmt, FMT_I);
    try_op(enc(F7_ALT, 3'h0, OPC_OP), OP_SUB);
    check("rd_r", rd, 5'h03);
    check("imm_r", imm, 32'h0);
  endtask : run_imms

  task automatic run_events();
    logic [31:0] ew [14] = '{32'h8330000F, 32'h0100000F, 32'h8330800F,
      32'h0330000F, 32'h00000073, 32'h00100073, 32'h00200073,
      32'h02000033, 32'h00001073, 32'h00001067, 32'h40001013,
      32'h0000006B, 32'h00003003, 32'h0000001F};
    rvd_op_type eo [14] = '{OP_FENCE_TSO, OP_PAUSE, OP_FENCE, OP_FENCE,
      OP_ECALL, OP_EBREAK, OP_ILLEGAL, OP_ILLEGAL, OP_ILLEGAL,
      OP_ILLEGAL, OP_ILLEGAL, OP_ILLEGAL, OP_ILLEGAL, OP_ILLEGAL};
    for (int k = 0; k < 14; k++)
    begin
      try_op(ew[k], eo[k]);
      check("fence_tso", fence_tso, eo[k] == OP_FENCE_TSO);
      check("is_fence", is_fence, k < 4);
      check("pause", pause_hint, eo[k] == OP_PAUSE);
      check("env_call", env_call, eo[k] == OP_ECALL);
      check("env_break", env_break, eo[k] == OP_EBREAK);
    end
  endtask : run_events

  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run

  // ****
  // Run control
  // ****
  initial
  begin
    forever #50 sys_clk = ~sys_clk;
  end

  initial
  begin
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
    run_map();
    run_groups();
    run_imms();
    run_events();
    complete_run();
  end

  initial
  begin
    repeat (3000) @(posedge sys_clk);
    error_cnt++;
    complete_run();
  end
endmodule : testbench

`default_nettype wire
